// *** hdl/misc_regs.sv ***
// Feature enable, branch stack top, debug control and exception branch record bank.
// Assumes an APB master on pclk and a branch unit that reports events on pclk.
`timescale 1ns/100ps
`default_nettype none
`include "misc_regs_defs.svh"

module misc_regs
#(
  parameter logic [7:0] LEAF_MAX_FULL = 8'h0a,
  parameter logic [15:0] NOMINAL_POINT = 16'h0000
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave port.
  input wire misc_regs_pkg::apb_req_t apb_req,
  output var misc_regs_pkg::apb_rsp_t apb_rsp,
  // Thermal inputs: sensor pin and throttle target from the control register.
  input wire logic die_at_threshold,
  input wire logic [15:0] thermal_throttle_control,
  // Branch unit events.
  input wire logic branch_taken,
  input wire logic exception_event,
  input wire misc_regs_pkg::branch_pair_t last_branch,
  // Feature controls.
  output logic thermal_throttle_level1,
  output logic thermal_throttle_level2,
  output logic [15:0] voltage_select_code,
  output logic dvfs_on,
  output logic wait_monitor_engine_on,
  output logic [7:0] cap_id_leaf_max,
  output logic no_execute_feature_off,
  output logic [63:0] debug_feature_control,
  output logic [9:0] branch_record_source_first
);

  import misc_regs_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Word index of an APB byte address.
  function automatic logic [9:0] word_index(input logic [11:0] addr);
    return addr[11:2];
  endfunction

  // True when the index names one of the 64-bit registers.
  function automatic logic is_wide(input logic [9:0] idx);
    return (idx == `IDX_FEATURE) || (idx == `IDX_DEBUG) || (idx == `IDX_EXC_SOURCE) ||
           (idx == `IDX_EXC_TARGET);
  endfunction

  // Full 64-bit value of a wide register.
  function automatic logic [63:0] wide_value(input state_t s, input logic [9:0] idx);
    logic [63:0] v;
    v = '0;
    case (idx)
      `IDX_FEATURE: v = s.feature;
      `IDX_DEBUG: v = s.debug;
      `IDX_EXC_SOURCE: v = s.exc.source;
      `IDX_EXC_TARGET: v = s.exc.target;
      default: v = '0;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // Sensor input
  // ****************************************************************

  logic die_hot;

  // The sensor is a pin from another domain, so it is filtered first.
  level_sync
  #(
    .WIDTH(1)
  )
  u_sensor_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(die_at_threshold),
    .sync_out(die_hot)
  );

  // ****************************************************************
  // State
  // ****************************************************************

  state_t st;
  state_t next_st;

  logic [9:0] idx;
  logic setup;
  logic access_done;
  logic wr;
  logic rd_setup;

  // Bus phase decode.
  assign idx = word_index(apb_req.paddr);
  assign setup = apb_req.psel && !apb_req.penable;
  assign access_done = apb_req.psel && apb_req.penable && st.rsp.pready;
  assign wr = access_done && apb_req.pwrite;
  assign rd_setup = setup && !apb_req.pwrite;

  // Next state of the whole bank.
  always_comb
  begin
    logic [63:0] wide;
    logic mapped;
    wide = '0;
    mapped = 1'b0;
    next_st = st;

    // The answer is prepared in the setup cycle so every bus output is a flop.
    // Cost: one access cycle always, but no combinational path to prdata.
    next_st.rsp.pready = setup;
    if (setup)
    begin
      mapped = is_wide(idx) || (idx == `IDX_STACK_TOP) || (idx == `IDX_HIGH_WORD);
      next_st.rsp.pslverr = !mapped;
      next_st.rsp.prdata = '0;
      if (!apb_req.pwrite)
      begin
        if (is_wide(idx))
        begin
          wide = wide_value(st, idx);
          next_st.rsp.prdata = wide[31:0];
        end
        else if (idx == `IDX_STACK_TOP)
        begin
          next_st.rsp.prdata = {28'h0000000, st.stack_top};
        end
        else if (idx == `IDX_HIGH_WORD)
        begin
          next_st.rsp.prdata = st.high_word;
        end
      end
    end
    else if (!apb_req.psel)
    begin
      next_st.rsp.pslverr = 1'b0;
    end

    // A low-word read snapshots the high half so the pair reads coherently.
    if (rd_setup && is_wide(idx))
    begin
      wide = wide_value(st, idx);
      next_st.high_word = wide[63:32];
    end

    // Branch stack top advances on each taken branch; a bus write to it at the same edge wins.
    if (branch_taken)
    begin
      next_st.stack_top = st.stack_top + 4'h1;
    end

    // Writes take effect at the access edge only.
    if (wr)
    begin
      case (idx)
        `IDX_HIGH_WORD: next_st.high_word = apb_req.pwdata;
        // Reserved feature bits are masked off and read back as zero.
        `IDX_FEATURE: next_st.feature = {st.high_word, apb_req.pwdata} & `FEATURE_WMASK;
        `IDX_DEBUG: next_st.debug = {st.high_word, apb_req.pwdata};
        `IDX_STACK_TOP: next_st.stack_top = apb_req.pwdata[`STACK_TOP_W-1:0];
        default: next_st.high_word = st.high_word;
      endcase
    end

    // Both halves of the exception record move in the same cycle; the bus cannot write them.
    if (exception_event)
    begin
      next_st.exc = last_branch;
    end

    // Level-2 throttle engages on bit 13 and the hot sensor.
    next_st.level2_engaged = st.feature[`BIT_LEVEL2] && die_hot;
    // Level-1 acts only where level 2 is not engaged.
    next_st.level1_engaged = st.feature[`BIT_LEVEL1] && die_hot && !st.feature[`BIT_LEVEL2];

    // Operating point follows the target only while level 2 holds.
    if (next_st.level2_engaged)
    begin
      next_st.operating_point = thermal_throttle_control;
    end
    else
    begin
      next_st.operating_point = NOMINAL_POINT;
    end

    // Leaf limit clamps the reported identification range.
    if (st.feature[`BIT_LEAF_LIMIT])
    begin
      next_st.leaf_max = `LEAF_LIMITED;
    end
    else
    begin
      next_st.leaf_max = LEAF_MAX_FULL;
    end

    // Record source register selected by the stack top, from base 40h.
    next_st.record_index = `IDX_RECORD_BASE + {6'h00, next_st.stack_top};
  end

  // Register the whole bank.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st.rsp <= '0;
      st.high_word <= `RST_WORD;
      st.feature <= `RST_FEATURE;
      st.debug <= `RST_DEBUG;
      st.stack_top <= '0;
      st.exc <= '0;
      st.level2_engaged <= 1'b0;
      st.level1_engaged <= 1'b0;
      st.operating_point <= 16'h0000;
      st.leaf_max <= 8'h00;
      st.record_index <= `IDX_RECORD_BASE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs, each a field of the state flop
  // ****************************************************************

  // Bus answer and feature controls.
  assign apb_rsp = st.rsp;
  assign thermal_throttle_level1 = st.level1_engaged;
  assign thermal_throttle_level2 = st.level2_engaged;
  assign voltage_select_code = st.operating_point;
  assign dvfs_on = st.feature[`BIT_DVFS];
  assign wait_monitor_engine_on = st.feature[`BIT_WAIT_MON];
  assign cap_id_leaf_max = st.leaf_max;
  assign no_execute_feature_off = st.feature[`BIT_NX_OFF];
  assign debug_feature_control = st.debug;
  assign branch_record_source_first = st.record_index;

endmodule
`default_nettype wire

// *** pkg/misc_regs_defs.svh ***
// Constants of the miscellaneous feature and branch record register bank.
// Assumes a 32-bit APB with byte addresses; register index times four is the byte address.
`ifndef MISC_REGS_DEFS_SVH
`define MISC_REGS_DEFS_SVH

// ****************************************************************
// Register indices, byte address is index times four
// ****************************************************************
`define IDX_FEATURE 10'h1a0
`define IDX_STACK_TOP 10'h1c9
`define IDX_DEBUG 10'h1d9
`define IDX_EXC_SOURCE 10'h1dd
`define IDX_EXC_TARGET 10'h1de
`define IDX_HIGH_WORD 10'h3f0
`define IDX_RECORD_BASE 10'h040

// ****************************************************************
// Fields of the feature enable register, and the stack top width
// ****************************************************************
`define BIT_LEVEL1 3
`define BIT_LEVEL2 13
`define BIT_DVFS 16
`define BIT_WAIT_MON 18
`define BIT_LEAF_LIMIT 22
`define BIT_NX_OFF 34
`define FEATURE_WMASK 64'h0000_0004_0045_2008
`define LEAF_LIMITED 8'h03
`define STACK_TOP_W 4

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_FEATURE 64'h0000_0000_0000_0000
`define RST_DEBUG 64'h0000_0000_0000_0000
`define RST_WORD 32'h0000_0000

`endif

// *** pkg/misc_regs_pkg.sv ***
// Types shared by the register bank, its checker and its bench.
// Assumes the constants header is on the include path.
`include "misc_regs_defs.svh"

package misc_regs_pkg;

  // APB request from the master.
  typedef struct packed
  {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // APB answer from the slave.
  typedef struct packed
  {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  // Capture of the last branch before an exception.
  typedef struct packed
  {
    logic [63:0] source;
    logic [63:0] target;
  } branch_pair_t;

  // Whole state of the register bank.
  typedef struct packed
  {
    apb_rsp_t rsp;
    logic [31:0] high_word;
    logic [63:0] feature;
    logic [63:0] debug;
    logic [`STACK_TOP_W-1:0] stack_top;
    branch_pair_t exc;
    logic level2_engaged;
    logic level1_engaged;
    logic [15:0] operating_point;
    logic [7:0] leaf_max;
    logic [9:0] record_index;
  } state_t;

endpackage

// *** hdl/level_sync.sv ***
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none

module level_sync
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous level in, filtered level out.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Stage one feeds only stage two, so a metastable value never reaches logic.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++)
      begin
        if (stage2[i] == stage3[i])
        begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** sim/misc_regs_checker.sv ***
// Concurrent checks on the ports of the feature and branch record bank.
// Assumes it is bound into misc_regs and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none

module misc_regs_checker
#(
  parameter logic [7:0] LEAF_MAX_FULL = 8'h0a,
  parameter logic [15:0] NOMINAL_POINT = 16'h0000
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bus and event inputs.
  input wire misc_regs_pkg::apb_req_t apb_req,
  input wire misc_regs_pkg::apb_rsp_t apb_rsp,
  input wire logic [15:0] thermal_throttle_control,
  input wire logic branch_taken,
  // Outputs watched.
  input wire logic thermal_throttle_level1,
  input wire logic thermal_throttle_level2,
  input wire logic [15:0] voltage_select_code,
  input wire logic dvfs_on,
  input wire logic wait_monitor_engine_on,
  input wire logic [7:0] cap_id_leaf_max,
  input wire logic [63:0] debug_feature_control,
  input wire logic [9:0] branch_record_source_first
);
  import misc_regs_pkg::*;

  // ****************************************
  // Committed writes, decoded from the bus
  // ****************************************
  // A write lands only at the edge where pready is seen with the access phase.
  logic wr;
  assign wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Outputs may lag the register by one edge, so field checks look two edges on.
  property p_ready; apb_req.psel && !apb_req.penable |=> apb_rsp.pready; endproperty
  a_ready: assert property (p_ready) else $error("no pready after setup");
  property p_ready_once; apb_rsp.pready |=> !apb_rsp.pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready held too long");
  property p_dvfs; wr && apb_req.paddr == 12'h680 |-> ##2 dvfs_on == $past(apb_req.pwdata[16], 2); endproperty
  a_dvfs: assert property (p_dvfs) else $error("dvfs_on wrong");
  property p_wait; wr && apb_req.paddr == 12'h680 |-> ##2 wait_monitor_engine_on == $past(apb_req.pwdata[18], 2);
  endproperty
  a_wait: assert property (p_wait) else $error("wait monitor wrong");
  property p_leaf; wr && apb_req.paddr == 12'h680 |-> ##2
    cap_id_leaf_max == ($past(apb_req.pwdata[22], 2) ? 8'h03 : LEAF_MAX_FULL); endproperty
  a_leaf: assert property (p_leaf) else $error("leaf limit wrong");
  property p_volt; thermal_throttle_level2 |-> voltage_select_code == $past(thermal_throttle_control); endproperty
  a_volt: assert property (p_volt) else $error("throttle target not applied");
  property p_nominal; !thermal_throttle_level2 && $past(presetn) |-> voltage_select_code == NOMINAL_POINT; endproperty
  a_nominal: assert property (p_nominal) else $error("voltage moved while idle");
  property p_excl; !(thermal_throttle_level1 && thermal_throttle_level2); endproperty
  a_excl: assert property (p_excl) else $error("both throttle levels on");
  property p_top; branch_taken && !(wr && apb_req.paddr == 12'h724) |=>
    branch_record_source_first == {6'h04, $past(branch_record_source_first[3:0]) + 4'h1}; endproperty
  a_top: assert property (p_top) else $error("record index not advanced");
  property p_debug; wr && apb_req.paddr == 12'h764 |-> ##2 debug_feature_control[31:0] == $past(apb_req.pwdata, 2);
  endproperty
  a_debug: assert property (p_debug) else $error("debug output wrong");

  // Main scenarios reached.
  c_feature: cover property (wr && apb_req.paddr == 12'h680);
  c_hot: cover property (thermal_throttle_level2);
  c_branch: cover property (branch_taken);
  c_error: cover property (apb_rsp.pslverr);
endmodule

bind misc_regs misc_regs_checker #(.LEAF_MAX_FULL(LEAF_MAX_FULL), .NOMINAL_POINT(NOMINAL_POINT))
  misc_regs_checker_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .thermal_throttle_control(thermal_throttle_control), .branch_taken(branch_taken),
  .thermal_throttle_level1(thermal_throttle_level1), .thermal_throttle_level2(thermal_throttle_level2),
  .voltage_select_code(voltage_select_code), .dvfs_on(dvfs_on), .wait_monitor_engine_on(wait_monitor_engine_on),
  .cap_id_leaf_max(cap_id_leaf_max), .debug_feature_control(debug_feature_control),
  .branch_record_source_first(branch_record_source_first));

`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the feature and branch record bank over APB.
// Assumes the package and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb;
  import misc_regs_pkg::*;

  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  localparam logic [7:0] LEAF = 8'h0c;
  localparam logic [15:0] NOM = 16'h0011;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_t apb_req = '0;
  apb_rsp_t apb_rsp;
  logic die_at_threshold = 1'b0;
  logic [15:0] ttc = 16'h5a3c;
  logic branch_taken = 1'b0;
  logic exception_event = 1'b0;
  branch_pair_t last_branch = '0;
  logic lvl1, lvl2, dvfs, wmon, nxoff;
  logic [15:0] vsel;
  logic [7:0] leaf;
  logic [63:0] dbg;
  logic [9:0] rec;
  logic [31:0] v;
  logic e;
  int mismatches = 0;
  int cmp_count = 0;

  misc_regs #(.LEAF_MAX_FULL(LEAF), .NOMINAL_POINT(NOM)) misc_regs_inst (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .die_at_threshold(die_at_threshold), .thermal_throttle_control(ttc),
    .branch_taken(branch_taken), .exception_event(exception_event), .last_branch(last_branch),
    .thermal_throttle_level1(lvl1), .thermal_throttle_level2(lvl2), .voltage_select_code(vsel), .dvfs_on(dvfs),
    .wait_monitor_engine_on(wmon), .cap_id_leaf_max(leaf), .no_execute_feature_off(nxoff),
    .debug_feature_control(dbg), .branch_record_source_first(rec));

  // Free-running 200 MHz clock.
  initial
  begin
    forever #2.5 pclk = ~pclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; the request stands until pready is seen at an edge.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd_v,
    output logic er);
    int n;
    @(posedge pclk);
    apb_req <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (apb_rsp.pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      mismatches++;
      summarize();
    end
    rd_v = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, v, e);
    chk("write error", 1'b0, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, v, e);
    chk("read data", exp, v);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h680, 32'h0);
    rd(12'h724, 32'h0);
    chk("leaf max", LEAF, leaf);
    chk("record index", 10'h040, rec);
    wr(12'hfc0, '1);
    wr(12'h680, '1); // Capability flag taken as set, so bit 13 may change
    rd(12'h680, 32'h0045_2008);
    rd(12'hfc0, 32'h0000_0004);
    chk("feature outputs", 4'hf, {dvfs, wmon, nxoff, leaf == 8'h03});
    // Heat with level 2 on, then level 1 only, then neither.
    die_at_threshold <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("hot level2", {2'b01, ttc}, {lvl1, lvl2, vsel});
    wr(12'hfc0, 32'h0);
    wr(12'h680, 32'h0000_0008);
    repeat (3) @(posedge pclk);
    chk("hot level1", {2'b10, NOM}, {lvl1, lvl2, vsel});
    wr(12'h680, 32'h0);
    repeat (3) @(posedge pclk);
    chk("hot none", {2'b00, NOM, LEAF}, {lvl1, lvl2, vsel, leaf});
    // Both levels off is only a brief test state, so level 1 goes straight back on.
    wr(12'h680, 32'h0000_0008);
    die_at_threshold <= 1'b0;
    // Stack top wraps from 14 through 15 to 1.
    wr(12'h724, 32'hffff_fffe);
    rd(12'h724, 32'h0000_000e);
    chk("record index", 10'h04e, rec);
    branch_taken <= 1'b1;
    repeat (3) @(posedge pclk);
    branch_taken <= 1'b0;
    rd(12'h724, 32'h0000_0001);
    chk("record index", 10'h041, rec);
    wr(12'hfc0, 32'h1234_5678);
    wr(12'h764, 32'h9abc_def0);
    rd(12'h764, 32'h9abc_def0);
    rd(12'hfc0, 32'h1234_5678);
    chk("debug output", 64'h1234_5678_9abc_def0, dbg);
    // Capture one branch pair, then change the pair so a late capture shows.
    last_branch <= {64'h0123_4567_89ab_cdef, 64'hfedc_ba98_7654_3210};
    exception_event <= 1'b1;
    @(posedge pclk);
    exception_event <= 1'b0;
    last_branch <= '0;
    rd(12'h774, 32'h89ab_cdef);
    rd(12'hfc0, 32'h0123_4567);
    rd(12'h778, 32'h7654_3210);
    rd(12'hfc0, 32'hfedc_ba98);
    wr(12'h774, 32'h0);
    rd(12'h774, 32'h89ab_cdef);
    xfer(1'b0, 12'h800, 32'h0, v, e);
    chk("unmapped read", 33'h1_0000_0000, {e, v});
    summarize();
  end
endmodule

`default_nettype wire
